// ---- design/toa_addsub.v ----
`timescale 1ns/100ps
`default_nettype none
`include "toa_defines.vh"

module toa_addsub (
  input wire [`TOA_DW-1:0] a,
  input wire [`TOA_DW-1:0] b,
  input wire subtract,
  output wire [`TOA_DW-1:0] sum64,
  output wire [`TOA_DW-1:0] sum32_ext,
  output wire ovf64,
  output wire ovf32
);
  wire [`TOA_DW-1:0] b_eff;
  wire [`TOA_DW-1:0] raw;

  assign b_eff = subtract ? ~b : b;
  assign raw = a + b_eff + {{(`TOA_DW-1){1'b0}}, subtract};
  assign sum64 = raw;
  // Word result sign-extended from bit 31
  assign sum32_ext = {{32{raw[`TOA_WORD_MSB]}}, raw[`TOA_WORD_MSB:0]};
  // Signed overflow: operands agree in sign, result differs
  assign ovf64 = (a[63] == b_eff[63]) && (raw[63] != a[63]);
  assign ovf32 = (a[31] == b_eff[31]) && (raw[31] != a[31]);
endmodule

`default_nettype wire

// ---- design/toa_alu.v ----
`timescale 1ns/100ps
`default_nettype none
`include "toa_defines.vh"

// Contract
// - Trapping word add writes the 32-bit sum and raises an exception on signed overflow.
// - Non-trapping word add writes the 32-bit sum and never raises overflow.
// - Both word subtracts write first source minus second source as a 32-bit difference.
// - Set-if-less writes one when first source is below second, signed or unsigned, else zero.
// - Conjunction writes the bitwise AND of both sources.
// - Disjunction writes the bitwise OR of both sources.
// - Exclusive disjunction writes the bitwise XOR of both sources.
// - Negated disjunction writes the inverted bitwise OR of both sources.
// - Trapping doubleword add writes the 64-bit sum and traps on signed overflow.
// - Non-trapping doubleword add writes the 64-bit sum and never traps.
// - Trapping doubleword subtract writes the 64-bit difference and traps on overflow.
// - Non-trapping doubleword subtract writes the 64-bit difference and never traps.
module toa_alu (
  input wire ref_clk,
  input wire rst,
  input wire issue_valid,
  input wire [`TOA_OP_W-1:0] op_select,
  input wire mode_64,
  input wire [`TOA_DW-1:0] first_source_register,
  input wire [`TOA_DW-1:0] second_source_register,
  input wire [`TOA_REG_AW-1:0] dest_index,
  output reg result_valid_r,
  output reg [`TOA_DW-1:0] result_r,
  output reg [`TOA_REG_AW-1:0] dest_index_r,
  output reg write_enable_r,
  output reg overflow_trap_r,
  output reg illegal_op_r
);
  // ==========================================================
  // Operation class decode
  // ==========================================================
  // One decode for adder mode, trap enable and width keeps them in step
  reg is_sub;
  reg is_dword;
  reg is_trapping;
  reg is_known;

  always @* begin
    is_sub = 1'b0;
    is_dword = 1'b0;
    is_trapping = 1'b0;
    is_known = 1'b1;
    case (op_select)
      `TOA_OP_ADD_TRAP: begin
        is_trapping = 1'b1;
      end
      `TOA_OP_ADD_NOTRAP: begin
        is_trapping = 1'b0;
      end
      `TOA_OP_SUB_TRAP: begin
        is_sub = 1'b1;
        is_trapping = 1'b1;
      end
      `TOA_OP_SUB_NOTRAP: begin
        is_sub = 1'b1;
        is_trapping = 1'b0;
      end
      `TOA_OP_LESS_SIGNED, `TOA_OP_LESS_UNSIGNED: begin
        // Comparators work on the operands directly
        is_sub = 1'b0;
      end
      `TOA_OP_AND, `TOA_OP_OR, `TOA_OP_XOR, `TOA_OP_NOR: begin
        // Gates need neither adder nor trap
        is_sub = 1'b0;
      end
      `TOA_OP_DW_ADD_TRAP: begin
        is_dword = 1'b1;
        is_trapping = 1'b1;
      end
      `TOA_OP_DW_ADD_NOTRAP: begin
        is_dword = 1'b1;
        is_trapping = 1'b0;
      end
      `TOA_OP_DW_SUB_TRAP: begin
        is_sub = 1'b1;
        is_dword = 1'b1;
        is_trapping = 1'b1;
      end
      `TOA_OP_DW_SUB_NOTRAP: begin
        is_sub = 1'b1;
        is_dword = 1'b1;
        is_trapping = 1'b0;
      end
      default: begin
        // Codes past the last operation
        is_known = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Shared adder
  // ==========================================================
  wire [`TOA_DW-1:0] sum64;
  wire [`TOA_DW-1:0] sum32_ext;
  wire ovf64;
  wire ovf32;

  toa_addsub u_addsub (
    .a(first_source_register),
    .b(second_source_register),
    .subtract(is_sub),
    .sum64(sum64),
    .sum32_ext(sum32_ext),
    .ovf64(ovf64),
    .ovf32(ovf32)
  );

  // Word results: sign-extended in 64-bit mode, upper half zero otherwise
  function [`TOA_DW-1:0] word_out;
    input [`TOA_DW-1:0] ext;
    input m64;
    begin
      word_out = m64 ? ext : {32'h00000000, ext[`TOA_WORD_MSB:0]};
    end
  endfunction

  // ==========================================================
  // Operation select
  // ==========================================================
  reg [`TOA_DW-1:0] result_nxt;
  reg trap_nxt;
  reg illegal_nxt;
  wire less_signed;
  wire less_unsigned;

  // Comparisons on the full width; word operands arrive sign-extended
  assign less_signed = $signed(first_source_register) < $signed(second_source_register);
  assign less_unsigned = first_source_register < second_source_register;

  // Each trapping form judges overflow at its own width only
  always @* begin
    trap_nxt = 1'b0;
    illegal_nxt = ~is_known;
    if (is_trapping) begin
      trap_nxt = is_dword ? ovf64 : ovf32;
    end
  end

  // ==========================================================
  // Result select
  // ==========================================================
  always @* begin
    result_nxt = `TOA_RESULT_RST;
    case (op_select)
      `TOA_OP_ADD_TRAP: begin
        result_nxt = word_out(sum32_ext, mode_64);
      end
      `TOA_OP_ADD_NOTRAP: begin
        result_nxt = word_out(sum32_ext, mode_64);
      end
      `TOA_OP_SUB_TRAP: begin
        result_nxt = word_out(sum32_ext, mode_64);
      end
      `TOA_OP_SUB_NOTRAP: begin
        result_nxt = word_out(sum32_ext, mode_64);
      end
      `TOA_OP_LESS_SIGNED: begin
        result_nxt = {63'h0, less_signed};
      end
      `TOA_OP_LESS_UNSIGNED: begin
        result_nxt = {63'h0, less_unsigned};
      end
      `TOA_OP_AND: begin
        result_nxt = first_source_register & second_source_register;
      end
      `TOA_OP_OR: begin
        result_nxt = first_source_register | second_source_register;
      end
      `TOA_OP_XOR: begin
        result_nxt = first_source_register ^ second_source_register;
      end
      `TOA_OP_NOR: begin
        result_nxt = ~(first_source_register | second_source_register);
      end
      `TOA_OP_DW_ADD_TRAP: begin
        result_nxt = sum64;
      end
      `TOA_OP_DW_ADD_NOTRAP: begin
        result_nxt = sum64;
      end
      `TOA_OP_DW_SUB_TRAP: begin
        result_nxt = sum64;
      end
      `TOA_OP_DW_SUB_NOTRAP: begin
        result_nxt = sum64;
      end
      default: begin
        // Unknown code loads a cleared result; nothing is written
        result_nxt = `TOA_RESULT_RST;
      end
    endcase
  end

  // ==========================================================
  // Result stage
  // ==========================================================
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      result_valid_r <= 1'b0;
      result_r <= `TOA_RESULT_RST;
      dest_index_r <= `TOA_REG_RST;
      write_enable_r <= 1'b0;
      overflow_trap_r <= 1'b0;
      illegal_op_r <= 1'b0;
    end else begin
      result_valid_r <= issue_valid;
      dest_index_r <= issue_valid ? dest_index : dest_index_r;
      result_r <= issue_valid ? result_nxt : result_r;
      // An operation that raises the overflow trap, or an unknown one, never writes the destination
      write_enable_r <= issue_valid & ~trap_nxt & ~illegal_nxt;
      overflow_trap_r <= issue_valid & trap_nxt;
      illegal_op_r <= issue_valid & illegal_nxt;
    end
  end
endmodule

`default_nettype wire

// ---- dv/three_operand_integer_alu_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module three_operand_integer_alu_tb;
  logic ref_clk = 0, rst = 1, iv = 0, m = 0;
  logic [3:0] op = 0;
  logic [63:0] a = 0, b = 0, big;
  logic [4:0] d = 0;
  logic [71:0] q[$], e, g;
  logic [31:0] r32;
  wire rvld, we, tr, il;
  wire [63:0] res;
  wire [4:0] dr;
  wire [15:0] nw, nt;
  integer seed = 41179, fail_count = 0, tests_run = 0, i, k, ew = 0, et = 0;
  initial forever #4 ref_clk = ~ref_clk;
  toa_alu dut_u (.ref_clk, .rst, .issue_valid(iv), .op_select(op), .mode_64(m),
    .first_source_register(a), .second_source_register(b), .dest_index(d), .result_valid_r(rvld),
    .result_r(res), .dest_index_r(dr), .write_enable_r(we), .overflow_trap_r(tr), .illegal_op_r(il));
  toa_pipe_model pm_u (.ref_clk, .rst, .write_enable_r(we), .overflow_trap_r(tr), .writes(nw),
    .traps(nt));
  // ==========================================
  function automatic [71:0] want(input [3:0] o, input [63:0] x, y, input mm, input [4:0] dd);
    logic [63:0] r;
    logic [31:0] s;
    logic ov, t, bad;
    s = o < 4'h2 ? x[31:0] + y[31:0] : x[31:0] - y[31:0];
    ov = (o < 4'h2) == (x[31] == y[31]) && s[31] != x[31];
    r = {mm ? {32{s[31]}} : 32'h0, s};
    case (o)
      4'h4: r = {63'h0, $signed(x) < $signed(y)};
      4'h5: r = {63'h0, x < y};
      4'h6: r = x & y;
      4'h7: r = x | y;
      4'h8: r = x ^ y;
      4'h9: r = ~(x | y);
      4'hA, 4'hB: r = x + y;
      4'hC, 4'hD: r = x - y;
    endcase
    if (o >= 4'hA)
      ov = (o < 4'hC) == (x[63] == y[63]) && r[63] != x[63];
    bad = o > 4'hD;
    t = ov && !o[0] && (o < 4'h4 || o >= 4'hA) && !bad;
    return {dd, bad ? 64'h0 : r, !t && !bad, t, bad};
  endfunction
  task chk(input [71:0] s, input [71:0] x);
    tests_run++;
    if (s !== x) begin
      fail_count++;
      $display("[ERR] %0t seen %h want %h", $time, s, x);
    end
  endtask
  task results;
    $display("tests %0d fails %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk) if (rvld === 1'b1) begin
    g = q.pop_front();
    chk({dr, res, we, tr, il}, g);
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 rst = 0;
    for (i = 0; i < 16; i++) for (k = 0; k < 6; k++) begin
      @(posedge ref_clk);
      #1 iv = 1;
      op = i[3:0];
      m = k[0];
      r32 = $random(seed);
      d = r32[4:0];
      a = {$random(seed), $random(seed)};
      b = {$random(seed), $random(seed)};
      big = i > 9 ? 64'h7FFFFFFFFFFFFFFF : 64'h7FFFFFFF;
      if (k < 2) begin
        a = k ? ~big : big;
        b = 64'h1;
      end
      if (i < 6) begin
        a = {{32{a[31]}}, a[31:0]};
        b = {{32{b[31]}}, b[31:0]};
      end
      e = want(op, a, b, m, d);
      ew += e[2];
      et += e[1];
      q.push_back(e);
    end
    @(posedge ref_clk);
    #1 iv = 0;
    repeat (3) @(posedge ref_clk);
    chk({40'h0, nw, nt}, {40'h0, ew[15:0], et[15:0]});
    chk({71'h0, q.size() != 0}, 72'h0);
    results;
  end
  initial begin
    #20000;
    fail_count++;
    results;
  end
endmodule
`default_nettype wire

// ---- dv/toa_alu_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module toa_alu_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic issue_valid,
  input wire logic [3:0] op_select,
  input wire logic mode_64,
  input wire logic [63:0] first_source_register,
  input wire logic [63:0] second_source_register,
  input wire logic [4:0] dest_index,
  input wire logic result_valid_r,
  input wire logic [63:0] result_r,
  input wire logic [4:0] dest_index_r,
  input wire logic write_enable_r,
  input wire logic overflow_trap_r
);
  // ==========================================
  // Short operand names keep each property but p_sext on one line
  wire [63:0] a = first_source_register;
  wire [63:0] b = second_source_register;
  wire go = issue_valid;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_answer; go |=> result_valid_r && dest_index_r == $past(dest_index); endproperty
  a_answer: assert property (p_answer) else $error("no answer after issue");
  property p_trap_nowr; overflow_trap_r |-> !write_enable_r; endproperty
  a_trap_nowr: assert property (p_trap_nowr) else $error("write on trap");
  property p_notrap; go && op_select[0] && op_select < 4'hE |=> !overflow_trap_r; endproperty
  a_notrap: assert property (p_notrap) else $error("trap on plain op");
  property p_and; go && op_select == 4'h6 |=> result_r == ($past(a) & $past(b)); endproperty
  a_and: assert property (p_and) else $error("and result wrong");
  property p_or; go && op_select == 4'h7 |=> result_r == ($past(a) | $past(b)); endproperty
  a_or: assert property (p_or) else $error("or result wrong");
  property p_nor; go && op_select == 4'h9 |=> result_r == ~($past(a) | $past(b)); endproperty
  a_nor: assert property (p_nor) else $error("nor result wrong");
  property p_dsum; go && op_select == 4'hB |=> result_r == $past(a) + $past(b); endproperty
  a_dsum: assert property (p_dsum) else $error("doubleword sum wrong");
  property p_sext; go && mode_64 && op_select < 4'h4 |=> result_r[63:32] == {32{result_r[31]}};
  endproperty
  a_sext: assert property (p_sext) else $error("word result not extended");
endmodule
bind toa_alu toa_alu_props props_u (.ref_clk, .rst, .issue_valid, .op_select, .mode_64,
  .first_source_register, .second_source_register, .dest_index, .result_valid_r, .result_r,
  .dest_index_r, .write_enable_r, .overflow_trap_r);
`default_nettype wire

// ---- dv/toa_pipe_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module toa_pipe_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic write_enable_r,
  input wire logic overflow_trap_r,
  output logic [15:0] writes,
  output logic [15:0] traps
);
  // ==========================================
  // Writeback and exception sink; counts only, no stall
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      writes <= 16'h0;
      traps <= 16'h0;
    end else begin
      writes <= writes + write_enable_r;
      traps <= traps + overflow_trap_r;
    end
  end
endmodule
`default_nettype wire

// ---- pkg/toa_defines.vh ----
`ifndef TOA_DEFINES_VH
`define TOA_DEFINES_VH

// Operation select codes
`define TOA_OP_W 4
`define TOA_OP_ADD_TRAP 4'h0
`define TOA_OP_ADD_NOTRAP 4'h1
`define TOA_OP_SUB_TRAP 4'h2
`define TOA_OP_SUB_NOTRAP 4'h3
`define TOA_OP_LESS_SIGNED 4'h4
`define TOA_OP_LESS_UNSIGNED 4'h5
`define TOA_OP_AND 4'h6
`define TOA_OP_OR 4'h7
`define TOA_OP_XOR 4'h8
`define TOA_OP_NOR 4'h9
`define TOA_OP_DW_ADD_TRAP 4'hA
`define TOA_OP_DW_ADD_NOTRAP 4'hB
`define TOA_OP_DW_SUB_TRAP 4'hC
`define TOA_OP_DW_SUB_NOTRAP 4'hD

// Widths and positions
`define TOA_DW 64
`define TOA_WORD_MSB 31
`define TOA_REG_AW 5

// Reset values
`define TOA_RESULT_RST 64'h0000000000000000
`define TOA_REG_RST 5'h00

`endif
